// ===== design/mdpp_defines.svh
// constants for the mode dependent port pin logic
`ifndef MDPP_DEFINES_SVH
`define MDPP_DEFINES_SVH

// register select codes on the cpu side
`define MDPP_SEL_A 4'h0
`define MDPP_SEL_B 4'h1
`define MDPP_SEL_C 4'h2
`define MDPP_SEL_D 4'h3
`define MDPP_SEL_E 4'h4
`define MDPP_SEL_F 4'h5
`define MDPP_SEL_G 4'h6
`define MDPP_SEL_DIR_A 4'h8
`define MDPP_SEL_DIR_C 4'hA
`define MDPP_SEL_DIR_D 4'hB
`define MDPP_SEL_DIR_G 4'hC

// mode pin codes {mode_select_high, mode_select_low}
`define MDPP_PINS_BOOT 2'h0
`define MDPP_PINS_TEST 2'h1
`define MDPP_PINS_SINGLE 2'h2
`define MDPP_PINS_EXPANDED 2'h3

// reset values
`define MDPP_LATCH_RST 8'h00
`define MDPP_DIR_RST 8'h00
`define MDPP_RDATA_RST 8'h00

`endif

// ===== design/mdpp_pkg.sv
// types for the mode dependent port pin logic
package mdpp_pkg;
    typedef enum logic [1:0] {
        MDPP_SINGLE,
        MDPP_EXPANDED,
        MDPP_BOOT,
        MDPP_TEST
    } mdpp_mode_t;
endpackage

// ===== design/mdpp_latch.sv
// one port data or direction latch written by the cpu
`timescale 1ns/1ns
`default_nettype none
module mdpp_latch #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // write side
    input wire logic wr_in,
    input wire logic [W-1:0] data_in,
    // held value
    output logic [W-1:0] q_out
);
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q_out <= RST;
        end else if (wr_in) begin
            q_out <= data_in;
        end
    end
endmodule
`default_nettype wire

// ===== design/mdpp_pin_drive.sv
// driver and readback logic for one group of port pins
`timescale 1ns/1ns
`default_nettype none
module mdpp_pin_drive #(
    parameter int W = 8
) (
    // software state
    input wire logic [W-1:0] latch_in,
    input wire logic [W-1:0] dir_in,
    // alternate function ownership
    input wire logic [W-1:0] alt_en_in,
    input wire logic [W-1:0] alt_val_in,
    // pin and option
    input wire logic [W-1:0] pin_in,
    input wire logic od_in,
    // results
    output logic [W-1:0] level_out,
    output logic [W-1:0] oe_out,
    output logic [W-1:0] read_out
);
    logic [W-1:0] drive_val;
    logic [W-1:0] drive_en;
    logic [W-1:0] od_mask;

    assign od_mask = {W{od_in}};
    // alternate function wins over the latch
    assign drive_val = (alt_en_in & alt_val_in) | (~alt_en_in & latch_in);
    assign drive_en = alt_en_in | dir_in;
    // open drain: only a zero is driven, a one floats
    assign level_out = drive_val & ~od_mask;
    assign oe_out = drive_en & ~(od_mask & drive_val);
    // outputs read back the driver input, inputs the pin
    assign read_out = (drive_en & drive_val) | (~drive_en & pin_in);
endmodule
`default_nettype wire

// ===== design/mdpp_port_pins.sv
// mode dependent multiplexing of the seven parallel ports
`timescale 1ns/1ns
`default_nettype none
`include "mdpp_defines.svh"

// Notes on behaviour
// - mode pins are sampled at reset and pick one of four modes.
// - after mode choice the instruction strobe is open drain, pull low only.
// - strobe pulls low the cycle after an opcode fetch, released otherwise.
// - expanded and test modes drive direction pin high read, low write.
// - direction pin stays low across back to back writes.
// - port reads give pin level for inputs, driver input for outputs.
// - timer port writes reach pins only for outputs not owned by compare.
// - timer port resets to inputs; direction decides when timer is off.
// - timer port doubles as capture, compare, pulse input; bit 3 selectable.
// - upper address port latches writes, drives in single chip or boot.
// - lower address port behaves likewise, lower address in expanded.
// - data bus port drives latch only as output in single chip or boot.
// - data bus port is input out of reset in single chip or boot, bus in expanded or test.
// - data bus port open drain option only in single chip or boot.
// - serial port open drain bit works in every mode.
// - serial port pins carry serial functions; latch drives only as output.
// - select port bits 7:4 carry the four chip selects when enabled.
// - select port open drain bit works in every mode.
module mdpp_port_pins
    import mdpp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // mode pins
    input wire logic mode_select_low_in,
    input wire logic mode_select_high_in,
    // cpu register access, one cycle per completed access
    input wire logic bus_valid_in,
    input wire logic bus_write_in,
    input wire logic [3:0] bus_sel_in,
    input wire logic [7:0] bus_wdata_in,
    output logic [7:0] bus_rdata_out,
    // cpu cycle state
    input wire logic opcode_fetch_in,
    input wire logic ext_cycle_in,
    input wire logic ext_write_in,
    input wire logic e_high_in,
    input wire logic [15:0] ext_addr_in,
    input wire logic [7:0] ext_wdata_in,
    output logic [7:0] ext_rdata_out,
    // option bits
    input wire logic data_port_open_drain_in,
    input wire logic serial_port_open_drain_in,
    input wire logic select_port_open_drain_in,
    // timer functions
    input wire logic [7:0] timer_oc_enable_in,
    input wire logic [7:0] timer_oc_value_in,
    input wire logic capture_channel_four_in,
    output logic [7:0] timer_capture_out,
    // serial functions
    input wire logic [5:0] serial_func_en_in,
    input wire logic [5:0] serial_func_oe_in,
    input wire logic [5:0] serial_func_val_in,
    output logic [5:0] serial_pin_out,
    // chip selects
    input wire logic chip_select_enable_in,
    input wire logic io_select_two_in,
    input wire logic io_select_one_in,
    input wire logic general_select_in,
    input wire logic program_select_in,
    // pins
    input wire logic [7:0] pa_pin_in,
    input wire logic [7:0] pc_pin_in,
    input wire logic [5:0] pd_pin_in,
    input wire logic [7:0] analog_input_port_in,
    input wire logic [7:0] pg_pin_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_out,
    output logic [7:0] pb_out,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe_out,
    output logic [5:0] pd_out,
    output logic [5:0] pd_oe_out,
    output logic [7:0] pf_out,
    output logic [7:0] pg_out,
    output logic [7:0] pg_oe_out,
    output logic instruction_start_strobe_out,
    output logic instruction_start_strobe_oe_out,
    output logic rw_out,
    // chosen mode
    output mdpp_mode_t mode_out,
    output logic mode_valid_out
);
    ////////////////////////////////////////////////////////////////////////
    // mode capture
    mdpp_mode_t mode_next;
    logic expanded;
    logic wr;

    always_comb begin
        case ({mode_select_high_in, mode_select_low_in})
            `MDPP_PINS_BOOT: mode_next = MDPP_BOOT;
            `MDPP_PINS_TEST: mode_next = MDPP_TEST;
            `MDPP_PINS_SINGLE: mode_next = MDPP_SINGLE;
            `MDPP_PINS_EXPANDED: mode_next = MDPP_EXPANDED;
            default: mode_next = MDPP_SINGLE;
        endcase
    end

    // async reset cannot load a pin, so the straps are taken at release
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_out <= MDPP_SINGLE;
            mode_valid_out <= 1'b0;
        end else if (!mode_valid_out) begin
            mode_out <= mode_next;
            mode_valid_out <= 1'b1;
        end
    end

    assign expanded = (mode_out == MDPP_EXPANDED) || (mode_out == MDPP_TEST);
    assign wr = bus_valid_in && bus_write_in;

    ////////////////////////////////////////////////////////////////////////
    // data and direction latches
    logic [7:0] a_latch, b_latch, c_latch, f_latch, g_latch;
    logic [7:0] a_dir, c_dir, g_dir;
    logic [5:0] d_latch, d_dir;

    mdpp_latch #(.W(8), .RST(`MDPP_LATCH_RST)) u_lat_a (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_A),
        .data_in(bus_wdata_in), .q_out(a_latch));
    mdpp_latch #(.W(8), .RST(`MDPP_LATCH_RST)) u_lat_b (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_B),
        .data_in(bus_wdata_in), .q_out(b_latch));
    mdpp_latch #(.W(8), .RST(`MDPP_LATCH_RST)) u_lat_c (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_C),
        .data_in(bus_wdata_in), .q_out(c_latch));
    mdpp_latch #(.W(6), .RST(6'(`MDPP_LATCH_RST))) u_lat_d (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_D),
        .data_in(bus_wdata_in[5:0]), .q_out(d_latch));
    mdpp_latch #(.W(8), .RST(`MDPP_LATCH_RST)) u_lat_f (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_F),
        .data_in(bus_wdata_in), .q_out(f_latch));
    mdpp_latch #(.W(8), .RST(`MDPP_LATCH_RST)) u_lat_g (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_G),
        .data_in(bus_wdata_in), .q_out(g_latch));
    mdpp_latch #(.W(8), .RST(`MDPP_DIR_RST)) u_dir_a (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_DIR_A),
        .data_in(bus_wdata_in), .q_out(a_dir));
    mdpp_latch #(.W(8), .RST(`MDPP_DIR_RST)) u_dir_c (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_DIR_C),
        .data_in(bus_wdata_in), .q_out(c_dir));
    mdpp_latch #(.W(6), .RST(6'(`MDPP_DIR_RST))) u_dir_d (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_DIR_D),
        .data_in(bus_wdata_in[5:0]), .q_out(d_dir));
    mdpp_latch #(.W(8), .RST(`MDPP_DIR_RST)) u_dir_g (.clk_in(clk_in),
        .rstn_in(rstn_in), .wr_in(wr && bus_sel_in == `MDPP_SEL_DIR_G),
        .data_in(bus_wdata_in), .q_out(g_dir));
    ////////////////////////////////////////////////////////////////////////
    // per port drivers
    logic [7:0] a_oc_en, a_lvl, a_oe, a_rd;
    logic [7:0] b_lvl, b_rd, c_lvl, c_oe, c_rd, f_lvl, f_rd;
    logic [7:0] g_alt_en, g_lvl, g_oe, g_rd;
    logic [5:0] d_lvl, d_oe, d_rd;
    logic c_bus_drive;

    // bit 3 as fourth capture gives up the fifth compare
    assign a_oc_en = timer_oc_enable_in
        & ~{4'h0, capture_channel_four_in, 3'h0};
    mdpp_pin_drive #(.W(8)) u_drv_a (
        .latch_in(a_latch), .dir_in(a_dir), .alt_en_in(a_oc_en),
        .alt_val_in(timer_oc_value_in), .pin_in(pa_pin_in), .od_in(1'b0),
        .level_out(a_lvl), .oe_out(a_oe), .read_out(a_rd));
    mdpp_pin_drive #(.W(8)) u_drv_b (
        .latch_in(b_latch), .dir_in(8'hFF), .alt_en_in({8{expanded}}),
        .alt_val_in(ext_addr_in[15:8]), .pin_in(8'h00), .od_in(1'b0),
        .level_out(b_lvl), .oe_out(), .read_out(b_rd));
    mdpp_pin_drive #(.W(8)) u_drv_f (
        .latch_in(f_latch), .dir_in(8'hFF), .alt_en_in({8{expanded}}),
        .alt_val_in(ext_addr_in[7:0]), .pin_in(8'h00), .od_in(1'b0),
        .level_out(f_lvl), .oe_out(), .read_out(f_rd));

    // data bus drives only during external writes
    assign c_bus_drive = expanded && ext_cycle_in && ext_write_in;
    mdpp_pin_drive #(.W(8)) u_drv_c (
        .latch_in(c_latch), .dir_in(c_dir & {8{!expanded}}),
        .alt_en_in({8{c_bus_drive}}), .alt_val_in(ext_wdata_in),
        .pin_in(pc_pin_in), .od_in(data_port_open_drain_in && !expanded),
        .level_out(c_lvl), .oe_out(c_oe), .read_out(c_rd));
    mdpp_pin_drive #(.W(6)) u_drv_d (
        .latch_in(d_latch), .dir_in(d_dir & ~serial_func_en_in),
        .alt_en_in(serial_func_en_in & serial_func_oe_in),
        .alt_val_in(serial_func_val_in), .pin_in(pd_pin_in),
        .od_in(serial_port_open_drain_in),
        .level_out(d_lvl), .oe_out(d_oe), .read_out(d_rd));

    assign g_alt_en = {{4{chip_select_enable_in}}, 4'h0};
    mdpp_pin_drive #(.W(8)) u_drv_g (
        .latch_in(g_latch), .dir_in(g_dir), .alt_en_in(g_alt_en),
        .alt_val_in({program_select_in, general_select_in,
                     io_select_one_in, io_select_two_in, 4'h0}),
        .pin_in(pg_pin_in), .od_in(select_port_open_drain_in),
        .level_out(g_lvl), .oe_out(g_oe), .read_out(g_rd));
    ////////////////////////////////////////////////////////////////////////
    // registered pin outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {pa_out, pa_oe_out, pb_out, pc_out, pc_oe_out} <= 40'h0000000000;
            {pd_out, pd_oe_out} <= 12'h000;
            {pf_out, pg_out, pg_oe_out} <= 24'h000000;
        end else begin
            {pa_out, pa_oe_out, pb_out, pc_out} <= {a_lvl, a_oe, b_lvl, c_lvl};
            {pc_oe_out, pd_out, pd_oe_out} <= {c_oe, d_lvl, d_oe};
            {pf_out, pg_out, pg_oe_out} <= {f_lvl, g_lvl, g_oe};
        end
    end
    // function inputs seen through the pins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {timer_capture_out, serial_pin_out} <= 14'h0000;
        end else begin
            timer_capture_out <= pa_pin_in;
            serial_pin_out <= pd_pin_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe and direction pin
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            instruction_start_strobe_out <= 1'b0;
            instruction_start_strobe_oe_out <= 1'b0;
        end else begin
            instruction_start_strobe_out <= 1'b0;
            instruction_start_strobe_oe_out <=
                mode_valid_out && opcode_fetch_in;
        end
    end

    // idle high; consecutive writes simply keep it low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rw_out <= 1'b1;
        end else begin
            rw_out <= !(expanded && ext_cycle_in && ext_write_in);
        end
    end

    // read data is taken only in the e high half
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_rdata_out <= `MDPP_RDATA_RST;
        end else if (expanded && ext_cycle_in && !ext_write_in
                     && e_high_in) begin
            ext_rdata_out <= pc_pin_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu read back
    logic [7:0] rd_mux;

    always_comb begin
        case (bus_sel_in)
            `MDPP_SEL_A: rd_mux = a_rd;
            `MDPP_SEL_B: rd_mux = b_rd;
            `MDPP_SEL_C: rd_mux = c_rd;
            `MDPP_SEL_D: rd_mux = {2'h0, d_rd};
            `MDPP_SEL_E: rd_mux = analog_input_port_in;
            `MDPP_SEL_F: rd_mux = f_rd;
            `MDPP_SEL_G: rd_mux = g_rd;
            `MDPP_SEL_DIR_A: rd_mux = a_dir;
            `MDPP_SEL_DIR_C: rd_mux = c_dir;
            `MDPP_SEL_DIR_D: rd_mux = {2'h0, d_dir};
            `MDPP_SEL_DIR_G: rd_mux = g_dir;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_rdata_out <= `MDPP_RDATA_RST;
        end else if (bus_valid_in && !bus_write_in) begin
            bus_rdata_out <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    mode_held_a: assert property (mode_valid_out |=> $stable(mode_out))
        else $error("mode changed after capture");
    strobe_od_a: assert property (instruction_start_strobe_out == 1'b0)
        else $error("strobe drove high");
    strobe_fetch_a: assert property (
        mode_valid_out ##0 opcode_fetch_in |=> instruction_start_strobe_oe_out
        ##1 (instruction_start_strobe_oe_out == $past(opcode_fetch_in)))
        else $error("strobe not tied to opcode fetch");
    rw_write_a: assert property (expanded && ext_cycle_in && ext_write_in
        |=> !rw_out)
        else $error("direction pin high on write");
    rw_hold_a: assert property (
        (expanded && ext_cycle_in && ext_write_in)[*2]
        |=> !rw_out && $past(!rw_out))
        else $error("direction pin rose between writes");
    oc_owns_a: assert property (a_oc_en[0] && wr && bus_sel_in == `MDPP_SEL_A
        |=> pa_out[0] == $past(timer_oc_value_in[0]))
        else $error("latch reached a compare owned pin");
    b_expanded_a: assert property (expanded |=>
        pb_out == $past(ext_addr_in[15:8]))
        else $error("upper address not on port");
    f_single_a: assert property (mode_valid_out && !expanded && !wr |=>
        ##1 pf_out == $past(f_latch, 2))
        else $error("lower port not driving latch");
    c_expanded_a: assert property (expanded && !c_bus_drive |=>
        pc_oe_out == 8'h00)
        else $error("data port driven outside writes");
    g_od_a: assert property (select_port_open_drain_in |=>
        (pg_oe_out & pg_out) == 8'h00)
        else $error("select port drove high in open drain");
    d_od_a: assert property (serial_port_open_drain_in |=>
        (pd_oe_out & pd_out) == 6'h00)
        else $error("serial port drove high in open drain");
    latch_load_a: assert property (wr && bus_sel_in == `MDPP_SEL_G
        |=> g_latch == $past(bus_wdata_in))
        else $error("latch missed write");
endmodule
`default_nettype wire

// ===== tb/mdpp_ext_mem.sv
// external memory model on the data bus and low address pins
`timescale 1ns/1ns
`default_nettype none
module mdpp_ext_mem (
    // clock and bus control
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic rw_in,
    input wire logic e_high_in,
    // address and data pins
    input wire logic [7:0] addr_in,
    input wire logic [7:0] pc_in,
    input wire logic [7:0] pc_oe_in,
    output logic [7:0] pc_pin_out
);
    logic [7:0] mem [16];
    logic drive;
    // answers reads only in the high half of e
    assign drive = en_in && rw_in && e_high_in;
    // pull-ups take released lines high
    assign pc_pin_out = (pc_oe_in & pc_in) |
        (~pc_oe_in & (drive ? mem[addr_in[3:0]] : 8'hFF));
    always_ff @(posedge clk_in) begin
        if (en_in && !rw_in) begin
            mem[addr_in[3:0]] <= pc_in;
        end
    end
endmodule
`default_nettype wire

// ===== tb/mdpp_port_pins_tb.sv
// self-checking bench for the mode dependent port pins
`timescale 1ns/1ns
`default_nettype none
`include "mdpp_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module mdpp_port_pins_tb;
    import mdpp_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [1:0] straps = 2'h0;
    logic bv = 1'b0, bwr = 1'b0, fetch = 1'b0, ecyc = 1'b0, ewr = 1'b0;
    logic ehi = 1'b0, cap4 = 1'b0, c_od = 1'b0, d_od = 1'b0, g_od = 1'b0;
    logic cs_en = 1'b0, mem_en = 1'b0;
    logic [3:0] bsel = 4'h0, cs_val = 4'h0;
    logic [7:0] bwd = 8'h00, ewd = 8'h00, oc_en = 8'h00, oc_val = 8'h00;
    logic [7:0] ext_a = 8'h00, ext_g = 8'h00, an_in = 8'h00;
    logic [5:0] s_en = 6'h00, s_oe = 6'h00, s_val = 6'h00, ext_d = 6'h00;
    logic [15:0] eaddr = 16'h0000;
    logic [7:0] brd, erd, cap_out, pa_o, pa_oe, pb_o, pc_o, pc_oe, pf_o;
    logic [7:0] pg_o, pg_oe;
    logic [5:0] s_in, pd_o, pd_oe;
    logic instruction_start_strobe, lir_oe, rw, mode_ok;
    mdpp_mode_t mode;
    wire logic [7:0] pa_pin, pc_pin, pg_pin;
    wire logic [5:0] pd_pin;
    int n_mismatch = 0;
    int cmp_count = 0;
    mdpp_mode_t mode_tab [4] = '{MDPP_BOOT, MDPP_TEST, MDPP_SINGLE,
        MDPP_EXPANDED};

    assign pa_pin = (pa_oe & pa_o) | (~pa_oe & ext_a);
    assign pd_pin = (pd_oe & pd_o) | (~pd_oe & ext_d);
    assign pg_pin = (pg_oe & pg_o) | (~pg_oe & ext_g);

    mdpp_port_pins mdpp_port_pins_i (
        .clk_in(clk_in), .rstn_in(rstn_in), .mode_select_low_in(straps[0]),
        .mode_select_high_in(straps[1]), .bus_valid_in(bv),
        .bus_write_in(bwr), .bus_sel_in(bsel), .bus_wdata_in(bwd),
        .bus_rdata_out(brd), .opcode_fetch_in(fetch), .ext_cycle_in(ecyc),
        .ext_write_in(ewr), .e_high_in(ehi), .ext_addr_in(eaddr),
        .ext_wdata_in(ewd), .ext_rdata_out(erd),
        .data_port_open_drain_in(c_od), .serial_port_open_drain_in(d_od),
        .select_port_open_drain_in(g_od), .timer_oc_enable_in(oc_en),
        .timer_oc_value_in(oc_val), .capture_channel_four_in(cap4),
        .timer_capture_out(cap_out), .serial_func_en_in(s_en),
        .serial_func_oe_in(s_oe), .serial_func_val_in(s_val),
        .serial_pin_out(s_in), .chip_select_enable_in(cs_en),
        .io_select_two_in(cs_val[0]), .io_select_one_in(cs_val[1]),
        .general_select_in(cs_val[2]), .program_select_in(cs_val[3]),
        .pa_pin_in(pa_pin), .pc_pin_in(pc_pin), .pd_pin_in(pd_pin),
        .analog_input_port_in(an_in), .pg_pin_in(pg_pin), .pa_out(pa_o),
        .pa_oe_out(pa_oe), .pb_out(pb_o), .pc_out(pc_o), .pc_oe_out(pc_oe),
        .pd_out(pd_o), .pd_oe_out(pd_oe), .pf_out(pf_o), .pg_out(pg_o),
        .pg_oe_out(pg_oe), .instruction_start_strobe_out(instruction_start_strobe),
        .instruction_start_strobe_oe_out(lir_oe), .rw_out(rw),
        .mode_out(mode), .mode_valid_out(mode_ok));
    mdpp_ext_mem mdpp_ext_mem_i (.clk_in(clk_in), .en_in(mem_en),
        .rw_in(rw), .e_high_in(ehi), .addr_in(pf_o), .pc_in(pc_o),
        .pc_oe_in(pc_oe), .pc_pin_out(pc_pin));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] od_keep(input logic od,
        input logic [7:0] v);
        // open drain floats the ones
        return od ? ~v : 8'hFF;
    endfunction
    task automatic bus_wr(input logic [3:0] sel, input logic [7:0] d);
        @(negedge clk_in);
        bv = 1'b1;
        bwr = 1'b1;
        bsel = sel;
        bwd = d;
        @(negedge clk_in);
        bv = 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] sel, output logic [7:0] d);
        @(negedge clk_in);
        bv = 1'b1;
        bwr = 1'b0;
        bsel = sel;
        @(negedge clk_in);
        bv = 1'b0;
        d = brd;
    endtask
    task automatic do_reset(input logic [1:0] code);
        @(negedge clk_in);
        rstn_in = 1'b0;
        straps = code;
        mem_en = code[0];
        repeat (5) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (2) @(negedge clk_in);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] lat, lat2, dir, dir2, oc, oe, dv, rd, cm, gv;
        logic [7:0] wd [2];
        logic [5:0] dm, dv6, oe6;
        void'($urandom(58));
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            `CHK("mode", mode_tab[m], mode)
            `CHK("mode valid", 1'b1, mode_ok)
        end
        $display("test modes done");
        fetch = 1'b1;
        @(negedge clk_in);
        fetch = 1'b0;
        `CHK("strobe oe", 1'b1, lir_oe)
        `CHK("strobe level", 1'b0, instruction_start_strobe)
        @(negedge clk_in);
        `CHK("strobe oe", 1'b0, lir_oe)
        `CHK("bus idle", 8'h00, pc_oe)
        // open drain set to show it has no hold on the bus
        c_od = 1'b1;
        ecyc = 1'b1;
        ewr = 1'b1;
        for (int i = 0; i < 2; i++) begin
            eaddr = {8'($urandom), 7'h00, 1'(i)};
            ewd = 8'($urandom) | 8'h01;
            wd[i] = ewd;
            @(negedge clk_in);
            `CHK("rw", 1'b0, rw)
            `CHK("pc oe", 8'hFF, pc_oe)
            `CHK("pc data", wd[i], pc_o)
            `CHK("addr hi", eaddr[15:8], pb_o)
            `CHK("addr lo", eaddr[7:0], pf_o)
        end
        ewr = 1'b0;
        eaddr = 16'h0000;
        @(negedge clk_in);
        `CHK("rw", 1'b1, rw)
        ehi = 1'b1;
        @(negedge clk_in);
        ecyc = 1'b0;
        ehi = 1'b0;
        `CHK("ext read", wd[0], erd)
        $display("test external bus done");
        repeat (20) begin
            lat = 8'($urandom);
            lat2 = 8'($urandom);
            dir = 8'($urandom);
            d_od = 1'($urandom);
            s_en = d_od ? 6'h00 : 6'($urandom);
            s_oe = 6'($urandom);
            s_val = 6'($urandom);
            ext_d = 6'($urandom);
            g_od = 1'($urandom);
            cs_en = g_od ? 1'b0 : 1'($urandom);
            cs_val = 4'($urandom);
            ext_g = 8'($urandom);
            bus_wr(`MDPP_SEL_D, lat);
            bus_wr(`MDPP_SEL_DIR_D, dir);
            bus_wr(`MDPP_SEL_G, lat2);
            bus_wr(`MDPP_SEL_DIR_G, dir);
            repeat (2) @(negedge clk_in);
            dm = (dir[5:0] & ~s_en) | (s_en & s_oe);
            dv6 = (s_en & s_val) | (~s_en & lat[5:0]);
            oe6 = d_od ? (dir[5:0] & ~lat[5:0]) : dm;
            `CHK("pd oe", oe6, pd_oe)
            `CHK("pd level", dv6 & oe6, pd_o & pd_oe)
            `CHK("serial in", pd_pin, s_in)
            cm = cs_en ? 8'hF0 : 8'h00;
            gv = ({cs_val, 4'h0} & cm) | (~cm & lat2);
            oe = cm | (dir & ~cm & od_keep(g_od, lat2));
            `CHK("pg oe", oe, pg_oe)
            `CHK("pg level", gv & oe, pg_o & pg_oe)
            bus_rd(`MDPP_SEL_D, rd);
            `CHK("pd read", {2'b00, (dm & dv6) | (~dm & pd_pin)}, rd)
            bus_rd(`MDPP_SEL_G, rd);
            oe = cm | dir;
            `CHK("pg read", (oe & gv) | (~oe & pg_pin), rd)
        end
        $display("test serial and select ports done");
        do_reset(`MDPP_PINS_SINGLE);
        `CHK("pa oe", 8'h00, pa_oe)
        `CHK("pc oe", 8'h00, pc_oe)
        bus_rd(`MDPP_SEL_B, rd);
        `CHK("pb read", 8'h00, rd)
        ecyc = 1'b1;
        ewr = 1'b1;
        @(negedge clk_in);
        ecyc = 1'b0;
        ewr = 1'b0;
        @(negedge clk_in);
        `CHK("rw", 1'b1, rw)
        repeat (20) begin
            lat = 8'($urandom);
            lat2 = 8'($urandom);
            dir = 8'($urandom);
            dir2 = 8'($urandom);
            oc_en = 8'($urandom);
            oc_val = 8'($urandom);
            cap4 = 1'($urandom);
            c_od = 1'($urandom);
            ext_a = 8'($urandom);
            an_in = 8'($urandom);
            bus_wr(`MDPP_SEL_A, lat);
            bus_wr(`MDPP_SEL_DIR_A, dir);
            bus_wr(`MDPP_SEL_C, lat2);
            bus_wr(`MDPP_SEL_DIR_C, dir2);
            bus_wr(`MDPP_SEL_B, lat2);
            bus_wr(`MDPP_SEL_F, ~lat2);
            repeat (2) @(negedge clk_in);
            oc = oc_en & ~{4'h0, cap4, 3'h0};
            oe = dir | oc;
            dv = (oc & oc_val) | (~oc & lat);
            `CHK("pa oe", oe, pa_oe)
            `CHK("pa level", dv & oe, pa_o & pa_oe)
            `CHK("capture", pa_pin, cap_out)
            `CHK("pc oe", dir2 & od_keep(c_od, lat2), pc_oe)
            `CHK("pc level", lat2 & pc_oe, pc_o & pc_oe)
            `CHK("pb level", lat2, pb_o)
            `CHK("pf level", ~lat2, pf_o)
            bus_rd(`MDPP_SEL_A, rd);
            `CHK("pa read", (oe & dv) | (~oe & pa_pin), rd)
            bus_rd(`MDPP_SEL_C, rd);
            `CHK("pc read", (dir2 & lat2) | (~dir2 & pc_pin), rd)
            bus_rd(`MDPP_SEL_F, rd);
            `CHK("pf read", ~lat2, rd)
            bus_rd(`MDPP_SEL_E, rd);
            `CHK("pe read", an_in, rd)
        end
        $display("test general ports done");
        print_verdict();
    end

    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
